// >>> core/op_decode.sv
// Opcode decoder for the four instructions
`timescale 1ns/1ps
`include "op_exec_map.svh"
module op_decode
(
  input wire op_exec_pkg::instr_s instr,
  output op_exec_pkg::op_e op
);
  import op_exec_pkg::*;
  wire is_swap = instr.word[`OPC_HI:`OPC6_LO] == `OPC_SWAP_TOP;
  wire is_fxor = instr.word[`OPC_HI:`OPC6_LO] == `OPC_FXOR_TOP;
  wire is_lxor = instr.word[`OPC_HI:`OPC4_LO] == `OPC_LXOR_TOP;
  wire [2:0] sel = instr.word[`SEL_HI:`SEL_LO];
  // Selects outside 5..7 decode as no operation so no stray register loads
  wire is_dir = (instr.word[`OPC_HI:`OPC9_LO] == `OPC_DIR_TOP) && (sel >= `DIR_SEL_FIRST);
  assign op = !instr.valid ? op_none :
              is_swap ? nibble_swap_op :
              is_fxor ? file_xor_op :
              is_lxor ? literal_xor_op :
              is_dir ? direction_load_op : op_none;
endmodule

// >>> core/op_exec.sv
// Execute stage for nibble swap, direction load and XOR instructions
`timescale 1ns/1ps
`include "op_exec_map.svh"
module op_exec
(
  input wire logic clk,
  input wire logic rst,
  input wire op_exec_pkg::instr_s instr,
  output logic [4:0] file_addr,
  input wire logic [7:0] file_rdata,
  output op_exec_pkg::file_wr_s file_wr,
  output logic [7:0] w_reg,
  output logic zero_flag,
  output logic [7:0] dir5,
  output logic [7:0] dir6,
  output logic [7:0] dir7,
  output logic done
);
  import op_exec_pkg::*;

  // ==========================================
  // Helper functions
  function automatic logic [7:0] swap_nibbles(input logic [7:0] v);
    return {v[3:0], v[7:4]};
  endfunction

  // Shared by both XOR forms so the two results cannot drift apart
  function automatic logic [7:0] xor_bytes(input logic [7:0] a, input logic [7:0] b);
    return a ^ b;
  endfunction

  function automatic logic is_zero(input logic [7:0] v);
    return v == 8'h00;
  endfunction

  function automatic logic dir_hit(input op_e o, input logic [2:0] s, input logic [2:0] n);
    return (o == direction_load_op) && (s == n);
  endfunction

  // ==========================================
  // Registers
  logic [7:0] w_q;
  logic [7:0] w_d;
  logic z_q;
  logic z_d;
  file_wr_s fw_q;
  file_wr_s fw_d;
  logic [7:0] d5_q;
  logic [7:0] d5_d;
  logic [7:0] d6_q;
  logic [7:0] d6_d;
  logic [7:0] d7_q;
  logic [7:0] d7_d;
  logic done_q;
  logic done_d;

  // ==========================================
  // Decode
  op_e op;
  op_decode u_dec
  (
    .instr(instr),
    .op(op)
  );

  // ==========================================
  // Instruction fields
  wire [4:0] faddr = instr.word[`FADDR_HI:`FADDR_LO];
  wire [7:0] lit = instr.word[`LIT_HI:`LIT_LO];
  wire [2:0] sel = instr.word[`SEL_HI:`SEL_LO];
  wire to_file = instr.word[`DEST_BIT];

  // ==========================================
  // Operation strobes
  wire do_swap = op == nibble_swap_op;
  wire do_fxor = op == file_xor_op;
  wire do_lxor = op == literal_xor_op;
  wire is_fop = do_swap || do_fxor;
  wire is_xor = do_lxor || do_fxor;
  wire any_op = op != op_none;

  // ==========================================
  // File register read
  // Read address is combinational so the file register arrives in the same cycle
  assign file_addr = faddr;

  // ==========================================
  // Datapath
  wire [7:0] swapped = swap_nibbles(file_rdata);
  wire [7:0] fxor = xor_bytes(w_q, file_rdata);
  wire [7:0] lxor = xor_bytes(w_q, lit);
  wire [7:0] fres = do_swap ? swapped : fxor;
  wire [7:0] xres = do_lxor ? lxor : fxor;

  // ==========================================
  // Working register next value
  wire w_from_file = is_fop && !to_file;
  wire w_load = w_from_file || do_lxor;
  wire [7:0] w_src = do_lxor ? lxor : fres;
  assign w_d = w_load ? w_src : w_q;

  // ==========================================
  // Zero flag next value
  // Swap and direction load leave the zero flag untouched
  assign z_d = is_xor ? is_zero(xres) : z_q;

  // ==========================================
  // File register write next value
  wire fw_we = is_fop && to_file;
  assign fw_d = '{we: fw_we, addr: faddr, data: fres};

  // ==========================================
  // Direction registers next value
  // Selects 0 to 4 never reach here, the decoder refuses them
  assign d5_d = dir_hit(op, sel, `DIR_SEL_FIRST) ? w_q : d5_q;
  assign d6_d = dir_hit(op, sel, `DIR_SEL_MID) ? w_q : d6_q;
  assign d7_d = dir_hit(op, sel, `DIR_SEL_LAST) ? w_q : d7_q;

  // ==========================================
  // Completion strobe next value
  assign done_d = any_op;

  // ==========================================
  // Working register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      w_q <= `W_RESET;
    end
    else
    begin
      w_q <= w_d;
    end
  end

  // ==========================================
  // Zero flag
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      z_q <= `ZERO_RESET;
    end
    else
    begin
      z_q <= z_d;
    end
  end

  // ==========================================
  // File register write port
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fw_q <= `FWR_RESET;
    end
    else
    begin
      fw_q <= fw_d;
    end
  end

  // ==========================================
  // Direction register 5
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      d5_q <= `DIR_RESET;
    end
    else
    begin
      d5_q <= d5_d;
    end
  end

  // ==========================================
  // Direction register 6
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      d6_q <= `DIR_RESET;
    end
    else
    begin
      d6_q <= d6_d;
    end
  end

  // ==========================================
  // Direction register 7
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      d7_q <= `DIR_RESET;
    end
    else
    begin
      d7_q <= d7_d;
    end
  end

  // ==========================================
  // Completion strobe
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      done_q <= `DONE_RESET;
    end
    else
    begin
      done_q <= done_d;
    end
  end

  // ==========================================
  // Outputs
  assign w_reg = w_q;
  assign zero_flag = z_q;
  assign file_wr = fw_q;
  assign dir5 = d5_q;
  assign dir6 = d6_q;
  assign dir7 = d7_q;
  assign done = done_q;

endmodule

// >>> core/op_exec_map.svh
// Constants for the nibble swap, direction load and XOR execute block
// ==========================================
// Functional notes
// - The nibble swap writes source bits 3:0 to result bits 7:4 and 7:4 to 3:0, no flag change.
// - For nibble swap and file XOR, a destination bit of 0 writes W, 1 writes the file register.
// - The direction load copies W into the direction register picked by a 3-bit field of 5 to 7.
// - The literal XOR writes W xor the low instruction byte into W and updates the zero flag.
// - The file XOR writes W xor the file register to the destination and updates only zero.
`ifndef OP_EXEC_MAP_SVH
`define OP_EXEC_MAP_SVH
`define OPC_SWAP_TOP 6'h0e
`define OPC_FXOR_TOP 6'h06
`define OPC_LXOR_TOP 4'hf
`define OPC_DIR_TOP 9'h000
`define DIR_SEL_FIRST 3'h5
`define DIR_SEL_MID 3'h6
`define DIR_SEL_LAST 3'h7
`define OPC_HI 11
`define OPC6_LO 6
`define OPC4_LO 8
`define OPC9_LO 3
`define FADDR_HI 4
`define FADDR_LO 0
`define LIT_HI 7
`define LIT_LO 0
`define SEL_HI 2
`define SEL_LO 0
`define DEST_BIT 5
`define W_RESET 8'h00
`define DIR_RESET 8'hff
`define ZERO_RESET 1'h0
`define FWR_RESET 14'h0000
`define DONE_RESET 1'h0
`endif

// >>> core/op_exec_pkg.sv
// Types for the nibble swap, direction load and XOR execute block
package op_exec_pkg;
  typedef enum {op_none, nibble_swap_op, direction_load_op, literal_xor_op, file_xor_op} op_e;
  typedef struct packed {
    logic valid;
    logic [11:0] word;
  } instr_s;
  typedef struct packed {
    logic we;
    logic [4:0] addr;
    logic [7:0] data;
  } file_wr_s;
endpackage

// >>> tb/nibble_swap_xor_tristate_ops_test.sv
// Bench for the execute block
`timescale 1ns/1ps
module nibble_swap_xor_tristate_ops_test;
  op_exec_pkg::instr_s instr = '0;
  op_exec_pkg::file_wr_s file_wr;
  logic clk = 1'h0, rst = 1'h1, ez = 1'h0, edn = 1'h0, ewe = 1'h0, zero_flag, done;
  logic [4:0] file_addr, ea = '0;
  logic [7:0] file_rdata = '0, ew = '0, efd = '0, w_reg, dir5, dir6, dir7;
  logic [7:0] ed[5:7] = '{3{8'hff}};
  logic [11:0] rw;
  logic [31:0] q = 32'he027e8df;
  int mismatches = 0, cmp_count = 0;
  always #4 clk = ~clk;
  op_exec dut (.clk, .rst, .instr, .file_addr, .file_rdata, .file_wr, .w_reg, .zero_flag,
    .dir5, .dir6, .dir7, .done);
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] expect_res(input logic [11:0] i, input logic [7:0] f,
    input logic [7:0] w);
    if (i[11:6] == 6'h0e)
      return {f[3:0], f[7:4]};
    return w ^ (i[11:8] == 4'hf ? i[7:0] : f);
  endfunction
  task chk(input logic ok);
    cmp_count++;
    mismatches += ok !== 1'h1;
    if (ok !== 1'h1) $display("mismatch at %0t: bad outputs", $time);
  endtask
  task wrap_up(input int late);
    mismatches += late;
    $display("mismatches %0d of %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Check at the falling edge, so the next word still goes out back to back
  task automatic step(input logic [11:0] i, input logic [7:0] f);
    logic s = i[11:6] == 6'h0e, x = i[11:6] == 6'h06, l = i[11:8] == 4'hf;
    logic t = i[11:3] == 9'h000 && i[2:0] > 3'h4;
    logic [7:0] r = expect_res(i, f, ew);
    instr <= {1'h1, i};
    file_rdata <= f;
    @(negedge clk);
    chk({w_reg, zero_flag, file_wr.we, done} === {ew, ez, ewe, edn});
    chk({dir5, dir6, dir7} === {ed[5], ed[6], ed[7]});
    chk(!ewe || {file_wr.addr, file_wr.data} === {ea, efd});
    chk(file_addr === i[4:0]);
    @(posedge clk);
    {edn, ewe, ea, efd} = {s | x | l | t, (s | x) & i[5], i[4:0], r};
    if (t) ed[i[2:0]] = ew;
    if (x | l) ez = r == 8'h00;
    if ((s | x | l) & !ewe) ew = r;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    step(12'h3a5, 8'ha5);
    step(12'h385, 8'h3c);
    step(12'h185, ew);
    $display("directed done");
    for (int k = 0; k < 300; k++)
    begin
      rw = q[13] ? {q[12] ? 6'h0e : 6'h06, q[5:0]} : q[12] ? {4'hf, q[7:0]} : {9'h000, q[2:0]};
      step(rw, q[31:24]);
      q = nx(q);
    end
    $display("random done");
    step(12'hfff, 8'h00);
    step(12'h007, 8'h00);
    repeat (2) step(12'h004, 8'h00);
    $display("corner done");
    wrap_up(0);
  end
  // A full run takes about 310 cycles, so this bound leaves a wide margin
  initial #20000 wrap_up(1);
endmodule

// >>> tb/op_exec_assertions.sv
// Port assertions for the execute block
`timescale 1ns/1ps
module op_exec_chk (
  input wire logic clk,
  input wire logic rst,
  input wire op_exec_pkg::instr_s instr,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] w_reg,
  input wire logic zero_flag,
  input wire logic [7:0] dir5,
  input wire op_exec_pkg::file_wr_s file_wr,
  input wire logic done
);
  wire [12:0] b = instr;
  wire s = b[12] && b[11:6] == 6'h0e, x = b[12] && b[11:6] == 6'h06, l = b[12] && b[11:8] == 4'hf;
  wire [7:0] n = {file_rdata[3:0], file_rdata[7:4]}, r = w_reg ^ (l ? b[7:0] : file_rdata);
  wire t = b[12] && b[11:3] == 9'h000 && b[2:0] > 3'h4;
  wire [7:0] fd = s ? n : r;
  default clocking c @(posedge clk); endclocking
  default disable iff (rst);
  AST_SWAP: assert property (s && !b[5] |=> w_reg == $past(n)) else $error("swap");
  AST_DEST: assert property ((s || x) && b[5] |=> $stable(w_reg)) else $error("dest");
  AST_DIR: assert property (b == 13'h1005 |=> dir5 == $past(w_reg)) else $error("dir");
  AST_LXOR: assert property (l |=> w_reg == $past(r)) else $error("lxor");
  AST_FXOR: assert property (x && !b[5] |=> w_reg == $past(r)) else $error("fxor");
  AST_ZERO: assert property (x || l |=> zero_flag == ($past(r) == 8'h00)) else $error("z");
  AST_WRITE: assert property ((s || x) && b[5] |=> file_wr == {1'h1, $past({b[4:0], fd})})
    else $error("write");
  AST_DONE: assert property (done == $past(s || x || l || t)) else $error("done");
endmodule
bind op_exec op_exec_chk u (.clk, .rst, .instr, .file_rdata, .w_reg, .zero_flag, .dir5,
  .file_wr, .done);
